// *** psu_addr_pkg.sv ***
/*
  Shared constants for the supply's bus address and alert logic: position
  decode windows, bus addresses, command codes, setpoint scaling, reset values.
  Assumes position and programming levels arrive as millivolt codes.
*/
package psu_addr_pkg;
  localparam int MV_W = 12;
  localparam int SP_W = 16;
  localparam int NUM_UNITS = 10;
  localparam int NUM_RACKS = 8;
  // unit thresholds (mV): 3150 2835 2505 2175 1845 1515 1185 855 525 180
  localparam logic [MV_W-1:0] UNIT_THRESH_MV [NUM_UNITS] = '{
    12'hc4e, 12'hb13, 12'h9c9, 12'h87f, 12'h735,
    12'h5eb, 12'h4a1, 12'h357, 12'h20d, 12'h0b4};
  // rack windows (mV), racks 1..8
  localparam logic [MV_W-1:0] RACK_MIN_MV [NUM_RACKS] = '{
    12'hc4e, 12'h3fc, 12'h708, 12'h226, 12'h622, 12'h320, 12'h546, 12'ha96};
  localparam logic [MV_W-1:0] RACK_MAX_MV [NUM_RACKS] = '{
    12'hd98, 12'h46a, 12'h7c6, 12'h258, 12'h6cc, 12'h370, 12'h5d2, 12'hbb8};
  localparam logic [3:0] ADDR_PREFIX = 4'h9;
  localparam logic [6:0] BCAST_ADDR = 7'h00;
  localparam logic [6:0] ARA_ADDR = 7'h0c;
  localparam logic [7:0] CMD_OPERATION = 8'h01;
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_VOUT_COMMAND = 8'h21;
  localparam logic [7:0] OPERATION_ON_BIT = 8'h80;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] READ_FILL = 8'h00;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;
  // 3000 mV input limit, 44000 mV floor, 54000 mV default
  localparam logic [MV_W-1:0] VPROG_LIMIT_MV = 12'hbb8;
  localparam logic [SP_W:0] SP_FLOOR_MV = 17'h0_abe0;
  localparam logic [SP_W-1:0] SP_DEFAULT_MV = 16'hd2f0;
  // 14000 mV span over 3000 mV input: gain 14/3
  localparam logic [SP_W:0] SP_GAIN_NUM = 17'h0_000e;
  localparam logic [SP_W:0] SP_GAIN_DEN = 17'h0_0003;
  // pin sync bits: scl, sda, slot, enable_n, rs485
  localparam logic [4:0] PIN_SYNC_RST = 5'h0b;
  localparam logic ALERT_RST = 1'b1;
  localparam logic OPERATION_ON_RST = 1'b1;
  localparam logic BUS_FREE_RST = 1'b1;
endpackage

// *** psu_bus_address_and_alert_logic.sv ***
/*
  Bus address, broadcast, alert-response and output-enable logic of a rack
  supply acting as a target on a two-wire management bus.
  Assumes scl_clk is the host bus clock (stands still between frames),
  position/programming levels are millivolt codes on clk_sys, and the
  testbench resolves the open-drain wires from the *_oe_n outputs.
*/
`timescale 1ns/1ps
`default_nettype none
module psu_bus_address_and_alert_logic (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic scl_clk,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  output logic alert_out,
  output logic alert_oe_n,
  input wire logic [psu_addr_pkg::MV_W-1:0] unit_position_sense_mv,
  input wire logic [psu_addr_pkg::MV_W-1:0] rack_position_sense_mv,
  input wire logic [psu_addr_pkg::MV_W-1:0] vprog_sense_mv,
  input wire logic slot_interlock_sense,
  input wire logic output_enable_n,
  input wire logic rs485_mode_sel,
  input wire logic state_change_event,
  output logic [3:0] position_address_bits,
  output logic [6:0] own_bus_address,
  output logic address_unconfigured,
  output logic main_output_on,
  output logic [psu_addr_pkg::SP_W-1:0] setpoint_mv,
  output logic sw_setpoint_active,
  output logic invalid_cmd_status,
  output logic alert_pending
);
  import psu_addr_pkg::*;

  typedef enum logic [2:0] {
    L_IDLE, L_ADDR, L_WRITE, L_READ, L_ARA, L_PEC, L_DONE
  } link_state_e;

  function automatic logic [7:0] crc_step(input logic [7:0] crc,
                                          input logic b);
    logic fb;
    fb = crc[7] ^ b;
    crc_step = {crc[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
  endfunction

  // sys domain: pin synchronisers and bus start/stop watch
  logic [4:0] pin_meta_q, pin_sync_q;
  logic scl_prev_q, sda_prev_q, bus_free_q, link_rst_n;
  logic scl_s, sda_s, slot_s, en_n_s, rs485_s;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pin_meta_q <= PIN_SYNC_RST;
      pin_sync_q <= PIN_SYNC_RST;
    end else begin
      pin_meta_q <= {rs485_mode_sel, output_enable_n, slot_interlock_sense,
                     sda_in, scl_clk};
      pin_sync_q <= pin_meta_q;
    end
  end

  assign scl_s = pin_sync_q[0];
  assign sda_s = pin_sync_q[1];
  assign slot_s = pin_sync_q[2];
  assign en_n_s = pin_sync_q[3];
  assign rs485_s = pin_sync_q[4];

  // holds the link logic in reset between frames, since scl gives no
  // edge to end a frame on; a stop also releases any drive on sda
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
      bus_free_q <= BUS_FREE_RST;
    end else begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
      if (scl_s && scl_prev_q && sda_prev_q && !sda_s) begin
        bus_free_q <= 1'b0;
      end else if (scl_s && scl_prev_q && !sda_prev_q && sda_s) begin
        bus_free_q <= 1'b1;
      end
    end
  end

  assign link_rst_n = rstn & ~bus_free_q;

  // sys to link: address and alert, quasi-static levels
  logic [8:0] to_link_meta_q, to_link_q;
  logic [6:0] own_l;
  logic own_valid_l, alert_l;
  logic [6:0] own_addr_q;
  logic addr_unconf_q, alert_q;

  always_ff @(posedge scl_clk or negedge rstn) begin
    if (!rstn) begin
      to_link_meta_q <= 9'h000;
      to_link_q <= 9'h000;
    end else begin
      to_link_meta_q <= {alert_q, ~addr_unconf_q, own_addr_q};
      to_link_q <= to_link_meta_q;
    end
  end

  assign own_l = to_link_q[6:0];
  assign own_valid_l = to_link_q[7];
  assign alert_l = to_link_q[8];

  // link domain, sampled on rising scl
  link_state_e st_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] sh_q, crc_q, byte_now, tx_byte;
  logic sda_hi_q, ack_q, lost_q, won_q, first_q;
  logic start_q, drive_low_q, tx_bit, tx_st;
  logic ev_rx, ev_bcast_rd, ev_win;

  assign byte_now = {sh_q[6:0], sda_in};
  assign tx_st = (st_q == L_READ) || (st_q == L_ARA) || (st_q == L_PEC);

  always_comb begin
    case (st_q)
      L_ARA: tx_byte = {own_l, 1'b1};
      L_PEC: tx_byte = crc_q;
      default: tx_byte = READ_FILL;
    endcase
  end

  assign tx_bit = tx_byte[3'd7 - bit_cnt_q[2:0]];

  assign ev_rx = !start_q && st_q == L_WRITE && bit_cnt_q == LAST_BIT;
  assign ev_bcast_rd = !start_q && st_q == L_ADDR && bit_cnt_q == LAST_BIT &&
                       byte_now == {BCAST_ADDR, 1'b1};
  assign ev_win = !start_q && st_q == L_ARA && bit_cnt_q == LAST_BIT &&
                  byte_now[7:1] == own_l;

  always_ff @(posedge scl_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      st_q <= L_IDLE;
      bit_cnt_q <= 4'h0;
      sh_q <= 8'h00;
      crc_q <= 8'h00;
      sda_hi_q <= 1'b1;
      ack_q <= 1'b0;
      lost_q <= 1'b0;
      won_q <= 1'b0;
      first_q <= 1'b0;
    end else begin
      sda_hi_q <= sda_in;
      if (start_q) begin
        st_q <= L_ADDR;
        bit_cnt_q <= 4'h1;
        sh_q <= {7'h00, sda_in};
        crc_q <= crc_step(8'h00, sda_in);
        ack_q <= 1'b0;
        lost_q <= 1'b0;
        won_q <= 1'b0;
        first_q <= 1'b1;
      end else if (st_q != L_IDLE && st_q != L_DONE) begin
        if (bit_cnt_q == ACK_SLOT) begin
          bit_cnt_q <= 4'h0;
          ack_q <= 1'b0;
          if (!ack_q) begin
            // host acknowledges our byte; a nack ends our answer
            case (st_q)
              L_READ: st_q <= sda_in ? L_DONE : L_READ;
              L_ARA: st_q <= (won_q && !sda_in) ? L_PEC : L_DONE;
              default: st_q <= L_DONE;
            endcase
          end
        end else begin
          sh_q <= byte_now;
          bit_cnt_q <= bit_cnt_q + 4'h1;
          if (st_q == L_ADDR || st_q == L_ARA) begin
            crc_q <= crc_step(crc_q, sda_in);
          end
          if (st_q == L_ARA && tx_bit && !sda_in) begin
            lost_q <= 1'b1;
          end
          if (bit_cnt_q == LAST_BIT) begin
            case (st_q)
              L_ADDR: begin
                if (own_valid_l && byte_now[7:1] == own_l) begin
                  ack_q <= 1'b1;
                  st_q <= byte_now[0] ? L_READ : L_WRITE;
                end else if (byte_now[7:1] == BCAST_ADDR) begin
                  ack_q <= !byte_now[0];
                  st_q <= byte_now[0] ? L_DONE : L_WRITE;
                end else if (byte_now == {ARA_ADDR, 1'b1} && alert_l &&
                             own_valid_l) begin
                  ack_q <= 1'b1;
                  st_q <= L_ARA;
                end else begin
                  st_q <= L_DONE;
                end
              end
              L_WRITE: ack_q <= 1'b1;
              L_ARA: won_q <= ev_win;
              default: ack_q <= 1'b0;
            endcase
          end
          if (st_q == L_WRITE && bit_cnt_q == LAST_BIT) begin
            first_q <= 1'b0;
          end
        end
      end
    end
  end

  // sda changes only while scl is low; falling sda with scl high is a start
  always_ff @(negedge scl_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      start_q <= 1'b0;
      drive_low_q <= 1'b0;
    end else begin
      start_q <= sda_hi_q & ~sda_in;
      if (sda_hi_q && !sda_in) begin
        drive_low_q <= 1'b0;
      end else if (bit_cnt_q == ACK_SLOT) begin
        drive_low_q <= ack_q;
      end else if (tx_st && !(st_q == L_ARA && lost_q)) begin
        drive_low_q <= ~tx_bit;
      end else begin
        drive_low_q <= 1'b0;
      end
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe_n = ~drive_low_q;

  // link events as toggles; data stays stable until the next byte
  logic rx_tgl_q, bcast_tgl_q, win_tgl_q, rx_first_q;
  logic [7:0] rx_byte_q;

  always_ff @(posedge scl_clk or negedge rstn) begin
    if (!rstn) begin
      rx_tgl_q <= 1'b0;
      bcast_tgl_q <= 1'b0;
      win_tgl_q <= 1'b0;
      rx_first_q <= 1'b0;
      rx_byte_q <= 8'h00;
    end else begin
      if (ev_rx) begin
        rx_tgl_q <= ~rx_tgl_q;
        rx_byte_q <= byte_now;
        rx_first_q <= first_q;
      end
      if (ev_bcast_rd) begin
        bcast_tgl_q <= ~bcast_tgl_q;
      end
      if (ev_win) begin
        win_tgl_q <= ~win_tgl_q;
      end
    end
  end

  logic [2:0] ev_meta_q, ev_sync_q, ev_seen_q, ev_pulse;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ev_meta_q <= 3'h0;
      ev_sync_q <= 3'h0;
      ev_seen_q <= 3'h0;
    end else begin
      ev_meta_q <= {win_tgl_q, bcast_tgl_q, rx_tgl_q};
      ev_sync_q <= ev_meta_q;
      ev_seen_q <= ev_sync_q;
    end
  end

  assign ev_pulse = ev_sync_q ^ ev_seen_q;

  // position decode
  logic [3:0] unit_num, rack_num;
  logic [7:0] map_val;
  logic map_ok;

  always_comb begin
    unit_num = 4'h0;
    rack_num = 4'h0;
    for (int i = 0; i < NUM_UNITS; i++) begin
      if (unit_position_sense_mv < UNIT_THRESH_MV[i]) begin
        unit_num = unit_num + 4'h1;
      end
    end
    for (int i = 0; i < NUM_RACKS; i++) begin
      if (rack_position_sense_mv >= RACK_MIN_MV[i] &&
          rack_position_sense_mv <= RACK_MAX_MV[i]) begin
        rack_num = 4'(i + 1);
      end
    end
  end

  always_comb begin
    map_ok = 1'b1;
    map_val = 8'h00;
    if (unit_num >= 4'h1 && unit_num <= 4'h4 &&
        rack_num >= 4'h1 && rack_num <= 4'h4) begin
      map_val = 8'({rack_num - 4'h1, 2'b00}) + 8'(unit_num - 4'h1);
    end else if (unit_num >= 4'h1 && unit_num <= 4'h5 &&
                 rack_num >= 4'h6 && rack_num <= 4'h8) begin
      map_val = 8'(8'(rack_num - 4'h6) * 8'h05) + 8'(unit_num - 4'h1);
    end else if ((unit_num == 4'h6 || unit_num == 4'h7) &&
                 rack_num >= 4'h1) begin
      map_val = 8'({rack_num - 4'h1, 1'b0}) + 8'(unit_num - 4'h6);
    end else if (unit_num >= 4'h8 && rack_num >= 4'h4) begin
      map_val = 8'(8'(rack_num - 4'h4) * 8'h03) + 8'(unit_num - 4'h8);
    end else begin
      map_ok = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      position_address_bits <= 4'h0;
      own_addr_q <= 7'h00;
      addr_unconf_q <= 1'b1;
    end else begin
      position_address_bits <= map_ok ? map_val[3:0] : 4'h0;
      // seven-bit form is 100 then all four position bits, so A3 is kept
      own_addr_q <= {ADDR_PREFIX[3:1], map_ok ? map_val[3:0] : 4'h0};
      addr_unconf_q <= ~map_ok;
    end
  end

  assign own_bus_address = own_addr_q;
  assign address_unconfigured = addr_unconf_q;

  // command bytes from own-address and broadcast writes
  logic [7:0] cmd_q, vout_lo_q;
  logic [1:0] dat_idx_q;
  logic got_byte, clear_faults;
  logic operation_on_q, sw_active_q, invalid_q;
  logic [SP_W-1:0] sw_sp_q;

  assign got_byte = ev_pulse[0];
  assign clear_faults = got_byte && rx_first_q &&
                        rx_byte_q == CMD_CLEAR_FAULTS;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cmd_q <= 8'h00;
      vout_lo_q <= 8'h00;
      dat_idx_q <= 2'h0;
      operation_on_q <= OPERATION_ON_RST;
      sw_active_q <= 1'b0;
      sw_sp_q <= SP_DEFAULT_MV;
    end else if (got_byte) begin
      if (rx_first_q) begin
        cmd_q <= rx_byte_q;
        dat_idx_q <= 2'h0;
      end else begin
        dat_idx_q <= (dat_idx_q == 2'h3) ? dat_idx_q : dat_idx_q + 2'h1;
        if (cmd_q == CMD_OPERATION && dat_idx_q == 2'h0) begin
          operation_on_q <= |(rx_byte_q & OPERATION_ON_BIT);
        end
        if (cmd_q == CMD_VOUT_COMMAND && dat_idx_q == 2'h0) begin
          vout_lo_q <= rx_byte_q;
        end
        if (cmd_q == CMD_VOUT_COMMAND && dat_idx_q == 2'h1) begin
          sw_sp_q <= {rx_byte_q, vout_lo_q};
          sw_active_q <= 1'b1;
        end
      end
    end
  end

  assign sw_setpoint_active = sw_active_q;

  // setpoint: hardware input until a software command takes over
  logic [SP_W:0] hw_sp;
  assign hw_sp = SP_FLOOR_MV +
                 (17'(vprog_sense_mv) * SP_GAIN_NUM) / SP_GAIN_DEN;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      setpoint_mv <= SP_DEFAULT_MV;
    end else if (sw_active_q) begin
      setpoint_mv <= sw_sp_q;
    end else if (vprog_sense_mv > VPROG_LIMIT_MV) begin
      setpoint_mv <= SP_DEFAULT_MV;
    end else begin
      setpoint_mv <= hw_sp[SP_W-1:0];
    end
  end

  // output control and alert
  logic out_on_d, slot_prev_q;
  assign out_on_d = slot_s && (rs485_s || !en_n_s) && operation_on_q;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      main_output_on <= 1'b0;
      slot_prev_q <= 1'b0;
    end else begin
      main_output_on <= out_on_d;
      slot_prev_q <= slot_s;
    end
  end

  // broadcast read raises invalid command; set wins over clear
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      invalid_q <= 1'b0;
    end else if (ev_pulse[1]) begin
      invalid_q <= 1'b1;
    end else if (clear_faults) begin
      invalid_q <= 1'b0;
    end
  end

  assign invalid_cmd_status = invalid_q;

  // powers up asserted so the host notices a new supply
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      alert_q <= ALERT_RST;
    end else if (state_change_event || ev_pulse[1] ||
                 out_on_d != main_output_on || slot_s != slot_prev_q) begin
      alert_q <= 1'b1;
    end else if (clear_faults || ev_pulse[2]) begin
      alert_q <= 1'b0;
    end
  end

  assign alert_pending = alert_q;
  assign alert_out = 1'b0;
  assign alert_oe_n = ~alert_q;
endmodule
`default_nettype wire

// *** psu_addr_props.sv ***
/*
  Checker for the address, alert and output-enable block.
  Assumes it is bound to the block and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module psu_addr_props import psu_addr_pkg::*; (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic scl_clk,
  input wire logic sda_oe_n,
  input wire logic alert_oe_n,
  input wire logic [psu_addr_pkg::MV_W-1:0] unit_position_sense_mv,
  input wire logic [psu_addr_pkg::MV_W-1:0] rack_position_sense_mv,
  input wire logic [psu_addr_pkg::MV_W-1:0] vprog_sense_mv,
  input wire logic slot_interlock_sense,
  input wire logic output_enable_n,
  input wire logic rs485_mode_sel,
  input wire logic state_change_event,
  input wire logic [3:0] position_address_bits,
  input wire logic [6:0] own_bus_address,
  input wire logic address_unconfigured,
  input wire logic main_output_on,
  input wire logic [psu_addr_pkg::SP_W-1:0] setpoint_mv,
  input wire logic sw_setpoint_active,
  input wire logic alert_pending
);
  import psu_addr_pkg::*;
  // cycles of scl high; longer than any bit means the bus is idle
  logic [5:0] scl_hi_q;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      scl_hi_q <= 6'h00;
    end else if (!scl_clk) begin
      scl_hi_q <= 6'h00;
    end else if (scl_hi_q != 6'h3f) begin
      scl_hi_q <= scl_hi_q + 6'h01;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  a_lock_gates_out: assert property (
    (!slot_interlock_sense)[*4] |-> !main_output_on) else $error("no lock");
  a_enable_gates: assert property (
    (!rs485_mode_sel && output_enable_n)[*4] |-> !main_output_on)
    else $error("on while disabled");
  a_rs485_ignores: assert property (
    (rs485_mode_sel && slot_interlock_sense)[*4] |-> main_output_on)
    else $error("rs485 mode off");
  a_own_addr_form: assert property (
    (!address_unconfigured && $stable(position_address_bits))[*2] |->
    own_bus_address == {3'b100, position_address_bits})
    else $error("bus address form");
  a_unit_open: assert property (
    (unit_position_sense_mv > 12'hc80)[*2] |=> address_unconfigured)
    else $error("open unit pin mapped");
  a_rack_none: assert property (
    (rack_position_sense_mv == 12'h67c && unit_position_sense_mv > 12'h5eb)[*2]
    |=> address_unconfigured) else $error("unassigned pair mapped");
  a_prog_default: assert property (
    (vprog_sense_mv > 12'hbb8 && !sw_setpoint_active)[*4] |=>
    sw_setpoint_active || setpoint_mv == SP_DEFAULT_MV)
    else $error("default setpoint");
  a_sw_holds: assert property (
    sw_setpoint_active && scl_hi_q > 6'h28 |=>
    sw_setpoint_active && $stable(setpoint_mv)) else $error("sw setpoint lost");
  a_alert_latched: assert property (
    alert_pending && scl_hi_q > 6'h28 |=> alert_pending)
    else $error("alert cleared while idle");
  a_event_alert: assert property (
    state_change_event |-> ##[1:3] !alert_oe_n) else $error("no alert");
  a_sda_on_low: assert property (
    $changed(sda_oe_n) |-> !scl_clk) else $error("sda moved with scl high");
  c_ara_clear: cover property ($fell(alert_pending));
  c_sw_set: cover property ($rose(sw_setpoint_active));
  c_out_on: cover property ($rose(main_output_on));
endmodule
bind psu_bus_address_and_alert_logic psu_addr_props u_props (
  .clk_sys, .rstn, .scl_clk, .sda_oe_n, .alert_oe_n, .unit_position_sense_mv,
  .rack_position_sense_mv, .vprog_sense_mv, .slot_interlock_sense,
  .output_enable_n, .rs485_mode_sel, .state_change_event,
  .position_address_bits, .own_bus_address, .address_unconfigured,
  .main_output_on, .setpoint_mv, .sw_setpoint_active, .alert_pending
);
`default_nettype wire

// *** smbus_host_model.sv ***
/*
  Host bus controller model: drives scl and pulls sda low.
  Assumes the bench resolves the pulled-up sda line and feeds it back.
*/
`timescale 1ns/1ps
`default_nettype none
module smbus_host_model (
  output logic scl_clk,
  output logic sda_pull,
  input wire logic sda_line
);
  // quarter bit in 15 ns ticks; keeps scl well under 400 kHz
  localparam int QTR = 70;
  logic tick_clk = 1'b0;
  initial begin
    scl_clk = 1'b1;
    sda_pull = 1'b0;
    #3.3;
    forever #7.5 tick_clk = ~tick_clk;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge tick_clk);
  endtask
  task automatic start();
    sda_pull = 1'b0;
    wt(QTR);
    scl_clk = 1'b1;
    wt(QTR);
    sda_pull = 1'b1;
    wt(2 * QTR);
    scl_clk = 1'b0;
    wt(QTR);
  endtask
  // sda moves only while scl is low
  task automatic bit_io(input logic b, output logic r);
    sda_pull = ~b;
    wt(QTR);
    scl_clk = 1'b1;
    wt(QTR);
    r = sda_line;
    wt(QTR);
    scl_clk = 1'b0;
    wt(QTR);
  endtask
  // eight data bits then the ack slot; rival emulates a lower responder
  task automatic xfer(input logic [7:0] tx, input logic [7:0] rival,
                      input logic ak_in, output logic [7:0] rx,
                      output logic ak);
    for (int i = 7; i >= 0; i--) bit_io(tx[i] & rival[i], rx[i]);
    bit_io(ak_in, ak);
  endtask
  task automatic stop();
    sda_pull = 1'b1;
    wt(QTR);
    scl_clk = 1'b1;
    wt(QTR);
    sda_pull = 1'b0;
    wt(2 * QTR);
  endtask
endmodule
`default_nettype wire

// *** tb_psu_bus_address_and_alert_logic.sv ***
/*
  Self-checking bench for the address, alert and output-enable block.
  Assumes the host model drives the bus and sda is pulled up.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_psu_bus_address_and_alert_logic;
  import psu_addr_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [MV_W-1:0] unit_position_sense_mv = 12'h000;
  logic [MV_W-1:0] rack_position_sense_mv = 12'h000;
  logic [MV_W-1:0] vprog_sense_mv = 12'h000;
  logic slot_interlock_sense = 1'b0;
  logic output_enable_n = 1'b1;
  logic rs485_mode_sel = 1'b0;
  logic state_change_event = 1'b0;
  logic scl_clk, sda_pull, sda_in, sda_out, sda_oe_n, alert_out, alert_oe_n;
  logic [3:0] position_address_bits;
  logic [6:0] own_bus_address;
  logic address_unconfigured, main_output_on, sw_setpoint_active;
  logic invalid_cmd_status, alert_pending;
  logic [SP_W-1:0] setpoint_mv;
  int error_cnt = 0;
  int checked = 0;
  int seed = 32'h0b4f_dc2b;
  logic [11:0] unit_lv [11] = '{12'hce4, 12'hbb8, 12'ha6e, 12'h924, 12'h7da,
    12'h690, 12'h546, 12'h3fc, 12'h2b2, 12'h168, 12'h000};
  logic [11:0] rack_lv [9] = '{12'h000, 12'hcee, 12'h42e, 12'h762, 12'h244,
    12'h67c, 12'h348, 12'h58c, 12'hb2c};
  logic [11:0] sp_lv [4] = '{12'h000, 12'hbb8, 12'hbb9, 12'hfff};
  assign sda_in = (sda_oe_n ? 1'b1 : sda_out) & ~sda_pull;
  always #50 clk_sys = ~clk_sys;
  psu_bus_address_and_alert_logic u_dut (.clk_sys, .rstn, .scl_clk, .sda_in,
    .sda_out, .sda_oe_n, .alert_out, .alert_oe_n, .unit_position_sense_mv,
    .rack_position_sense_mv, .vprog_sense_mv, .slot_interlock_sense,
    .output_enable_n, .rs485_mode_sel, .state_change_event,
    .position_address_bits, .own_bus_address, .address_unconfigured,
    .main_output_on, .setpoint_mv, .sw_setpoint_active, .invalid_cmd_status,
    .alert_pending);
  smbus_host_model u_host (.scl_clk, .sda_pull, .sda_line(sda_in));
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    c ^= d;
    repeat (8) c = c[7] ? {c[6:0], 1'b0} ^ CRC_POLY : {c[6:0], 1'b0};
    return c;
  endfunction
  // {unconfigured, bits}; unit 0 stands for the open pin
  function automatic logic [4:0] exp_addr(input int u, input int r);
    if (u == 0) return 5'h10;
    if (u <= 4 && r <= 4) return {1'b0, 4'(4 * (r - 1) + u - 1)};
    if (u <= 5 && r >= 6) return {1'b0, 4'(5 * (r - 6) + u - 1)};
    if (u == 6 || u == 7) return {1'b0, 4'(2 * (r - 1) + u - 6)};
    if (u >= 8 && r >= 4) return {1'b0, 4'(3 * (r - 4) + u - 8)};
    return 5'h10;
  endfunction
  function automatic logic [15:0] sp_exp(input logic [11:0] lv);
    if (lv > VPROG_LIMIT_MV) return SP_DEFAULT_MV;
    return 16'(SP_FLOOR_MV + lv * SP_GAIN_NUM / SP_GAIN_DEN);
  endfunction
  task automatic chk(input string nm, input logic [31:0] got, exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic results();
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // reads after the edge see the values settled before it
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic wait_alert(input logic v);
    int i;
    for (i = 0; i < 60 && alert_pending !== v; i++) tick(1);
    chk("alert_pending", alert_pending, v);
    if (alert_pending !== v) results();
  endtask
  task automatic wr(input logic [7:0] q [4], input int n, output logic nak);
    logic [7:0] c, rx;
    logic ak;
    c = 8'h00;
    nak = 1'b0;
    u_host.start();
    for (int i = 0; i < n; i++) begin
      u_host.xfer(q[i], 8'hff, 1'b1, rx, ak);
      nak |= ak;
      c = crc8(c, q[i]);
    end
    u_host.xfer(c, 8'hff, 1'b1, rx, ak);
    u_host.stop();
  endtask
  task automatic ara(input logic [7:0] rival, output logic [7:0] got,
                     output logic [7:0] pec, output logic ak);
    logic a2;
    u_host.start();
    u_host.xfer({ARA_ADDR, 1'b1}, 8'hff, 1'b1, got, ak);
    u_host.xfer(8'hff, rival, 1'b0, got, a2);
    u_host.xfer(8'hff, 8'hff, 1'b1, pec, a2);
    u_host.stop();
  endtask
  initial begin
    repeat (90000) @(posedge clk_sys);
    error_cnt++;
    results();
  end
  initial begin
    logic [4:0] e;
    logic [7:0] got, pec;
    logic ak;
    logic [15:0] v;
    logic [11:0] lv;
    tick(2);
    chk("alert_rst", alert_pending, 1'b1);
    chk("out_rst", main_output_on, 1'b0);
    chk("sp_rst", setpoint_mv, SP_DEFAULT_MV);
    tick(2);
    rstn <= 1'b1;
    tick(4);
    for (int u = 0; u < 11; u++) begin
      for (int r = 1; r < 9; r++) begin
        unit_position_sense_mv <= unit_lv[u];
        rack_position_sense_mv <= rack_lv[r];
        tick(4);
        e = exp_addr(u, r);
        chk("unconf", address_unconfigured, e[4]);
        chk("bits", position_address_bits, e[3:0]);
        if (!e[4]) chk("own", own_bus_address, {3'b100, e[3:0]});
      end
    end
    for (int i = 0; i < 8; i++) begin
      {slot_interlock_sense, output_enable_n, rs485_mode_sel} <= i[2:0];
      tick(6);
      chk("main_on", main_output_on, i[2] & (i[0] | ~i[1]));
    end
    for (int i = 0; i < 10; i++) begin
      lv = (i < 4) ? sp_lv[i] : 12'($unsigned($random(seed)) % 32'h0000_0bb9);
      vprog_sense_mv <= lv;
      tick(6);
      chk("setpoint", setpoint_mv, sp_exp(lv));
    end
    unit_position_sense_mv <= unit_lv[2];
    rack_position_sense_mv <= rack_lv[1];
    {slot_interlock_sense, output_enable_n} <= 2'b10;
    tick(6);
    wr('{8'h82, CMD_CLEAR_FAULTS, 8'h00, 8'h00}, 2, ak);
    chk("cf_ack", ak, 1'b0);
    wait_alert(1'b0);
    state_change_event <= 1'b1;
    tick(1);
    state_change_event <= 1'b0;
    wait_alert(1'b1);
    tick(3);
    chk("alert_pin", alert_oe_n, 1'b0);
    ara(8'h81, got, pec, ak);
    chk("ara_ack", ak, 1'b0);
    chk("ara_low", got, 8'h81);
    tick(20);
    chk("alert_kept", alert_pending, 1'b1);
    // alert line still low, so the host asks again
    ara(8'hff, got, pec, ak);
    chk("ara_own", got[7:1], 7'h41);
    chk("ara_pec", pec, crc8(crc8(8'h00, {ARA_ADDR, 1'b1}), got));
    wait_alert(1'b0);
    v = SP_FLOOR_MV[15:0] + 16'($unsigned($random(seed)) % 32'h0000_36b1);
    wr('{{BCAST_ADDR, 1'b0}, CMD_VOUT_COMMAND, v[7:0], v[15:8]}, 4, ak);
    chk("bc_ack", ak, 1'b0);
    tick(10);
    chk("bc_sp", setpoint_mv, v);
    chk("sw_act", sw_setpoint_active, 1'b1);
    vprog_sense_mv <= 12'h3e8;
    tick(10);
    chk("sp_hold", setpoint_mv, v);
    u_host.start();
    u_host.xfer({BCAST_ADDR, 1'b1}, 8'hff, 1'b1, got, ak);
    u_host.stop();
    chk("bcr_nak", ak, 1'b1);
    tick(10);
    chk("invalid", invalid_cmd_status, 1'b1);
    chk("bcr_alert", alert_pending, 1'b1);
    rstn <= 1'b0;
    tick(4);
    rstn <= 1'b1;
    tick(8);
    chk("sw_clr", sw_setpoint_active, 1'b0);
    chk("inv_clr", invalid_cmd_status, 1'b0);
    chk("sp_hw", setpoint_mv, sp_exp(12'h3e8));
    results();
  end
endmodule
`default_nettype wire
